// File: design/pth_consts.vh
// constants for the period timer with hardware limit
`ifndef PTH_CONSTS_VH
`define PTH_CONSTS_VH
`define PTH_CNT_RESET 8'h00
`define PTH_PER_RESET 8'hFF
`define PTH_MAJ_LSB 3
`define PTH_MAJ_MSB 4
`define PTH_OPT_LSB 0
`define PTH_OPT_MSB 2
`define PTH_MAJ_FREE 2'h0
`define PTH_MAJ_ONESHOT 2'h1
`define PTH_MAJ_MONO 2'h2
`define PTH_OPT_SWGATE 3'h0
`define PTH_OPT_GATE_HI 3'h1
`define PTH_OPT_GATE_LO 3'h2
`define PTH_OPT_ANY_EDGE 3'h3
`define PTH_OPT_RISE 3'h4
`define PTH_OPT_FALL 3'h5
`define PTH_OPT_LOW_RST 3'h6
`define PTH_OPT_HIGH_RST 3'h7
`define PTH_SRC_SEL_W 3
`endif

// File: design/pth_prescaler.v
// programmable prescaler producing a one-cycle timer clock tick
`timescale 1ns/100ps
module pth_prescaler (
  clock,
  rst_n,
  clear,
  ratio_sel,
  tick_in,
  tick_out
);
  input wire clock;
  input wire rst_n;
  input wire clear;
  input wire [2:0] ratio_sel;
  input wire tick_in;
  output reg tick_out;

  reg [6:0] count_q;
  wire [6:0] limit;

  // ratio is 1:2^ratio_sel, 1:1 up to 1:128
  assign limit = (7'h01 << ratio_sel) - 7'h01;

  always @(posedge clock) begin
    if (!rst_n || clear) begin
      count_q <= 7'h00;
      tick_out <= 1'b0;
    end else if (tick_in) begin
      if (count_q >= limit) begin
        count_q <= 7'h00;
        tick_out <= 1'b1;
      end else begin
        count_q <= count_q + 7'h01;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule // pth_prescaler

// File: design/pth_postscaler.v
// postscaler counting period matches and emitting the postscaled pulse
`timescale 1ns/100ps
module pth_postscaler (
  clock,
  rst_n,
  clear,
  postscale_select,
  match,
  hit
);
  input wire clock;
  input wire rst_n;
  input wire clear;
  input wire [3:0] postscale_select;
  input wire match;
  output reg hit;

  reg [3:0] count_q;

  always @(posedge clock) begin
    if (!rst_n || clear) begin
      count_q <= 4'h0;
      hit <= 1'b0;
    end else if (match) begin
      if (count_q >= postscale_select) begin
        count_q <= 4'h0;
        hit <= 1'b1;
      end else begin
        count_q <= count_q + 4'h1;
        hit <= 1'b0;
      end
    end else begin
      hit <= 1'b0;
    end
  end
endmodule // pth_postscaler

// File: design/pth_timer.v
// top of the 8-bit period timer with hardware limit modes
// Function
// - count advances on each prescaler tick
// - match signals postscaler, clears count next
// - hardware gate halts and resumes counting
// - reset: count zero, period all ones
// - pre/postscalers clear on count/control writes, resets
// - control write keeps count value
// - postscale hit gives one-cycle pulse
// - one-shot clears run bit at match
// - one-shot ignores postscale select
// - monostable stops, keeps run, restarts externally
// - interrupt flag sticky, enabled, software cleared
// - prescaler sync bit resyncs tick
// - run sync bit selects run alignment
// - five-bit mode field selects behaviour
// - debug mode ignores external triggers
// - mode 00000 software gate
// - modes 00001/00010 hardware gates
// - modes 00011-00101 edge resets
// - modes 00110/00111 level resets
// - reset source chosen by select register
// - one-shot match clears run, count zero
// - monostable match stops at zero
// - edge start needs fresh edge after run
`timescale 1ns/100ps
`include "pth_consts.vh"
module pth_timer (
  clock,
  rst_n,
  timer_clock,
  ext_sources,
  reset_source_select,
  debug_mode,
  count_wr,
  count_wdata,
  period_wr,
  period_wdata,
  ctrl_wr,
  run_wdata,
  prescale_wdata,
  postscale_wdata,
  limit_wr,
  mode_wdata,
  prescaler_sync_wdata,
  run_sync_wdata,
  timer_irq_enable,
  irq_flag_clear,
  count_value,
  period_value,
  run_bit,
  mode_q,
  postscaled_pulse,
  irq_flag,
  irq
);
  input wire clock;
  input wire rst_n;
  input wire timer_clock;
  input wire [7:0] ext_sources;
  input wire [2:0] reset_source_select;
  input wire debug_mode;
  input wire count_wr;
  input wire [7:0] count_wdata;
  input wire period_wr;
  input wire [7:0] period_wdata;
  input wire ctrl_wr;
  input wire run_wdata;
  input wire [2:0] prescale_wdata;
  input wire [3:0] postscale_wdata;
  input wire limit_wr;
  input wire [4:0] mode_wdata;
  input wire prescaler_sync_wdata;
  input wire run_sync_wdata;
  input wire timer_irq_enable;
  input wire irq_flag_clear;
  output reg [7:0] count_value;
  output reg [7:0] period_value;
  output reg run_bit;
  output reg [4:0] mode_q;
  output reg postscaled_pulse;
  output reg irq_flag;
  output reg irq;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [2:0] prescale_q;
  reg [3:0] postscale_select;
  reg prescaler_sync_bit;
  reg run_bit_sync;

  always @(posedge clock) begin
    if (!rst_n) begin
      prescale_q <= 3'h0;
      postscale_select <= 4'h0;
      mode_q <= 5'h00;
      prescaler_sync_bit <= 1'b0;
      run_bit_sync <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        prescale_q <= prescale_wdata;
        postscale_select <= postscale_wdata;
      end
      if (limit_wr) begin
        mode_q <= mode_wdata;
        prescaler_sync_bit <= prescaler_sync_wdata;
        run_bit_sync <= run_sync_wdata;
      end
    end
  end

  wire [1:0] major = mode_q[`PTH_MAJ_MSB:`PTH_MAJ_LSB];
  wire [2:0] option = mode_q[`PTH_OPT_MSB:`PTH_OPT_LSB];

  // ----------------------------------------------------------------
  // timer clock edge and external reset signal
  // ----------------------------------------------------------------
  reg tclk_q;
  reg ers_q;
  wire tclk_rise = timer_clock & ~tclk_q;
  wire ers_raw = ext_sources[reset_source_select];
  // debug mode freezes the sampled level so no trigger is seen
  wire ext_reset_signal = debug_mode ? ers_q : ers_raw;
  wire ers_rise = ext_reset_signal & ~ers_q;
  wire ers_fall = ~ext_reset_signal & ers_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      tclk_q <= 1'b0;
      ers_q <= 1'b0;
    end else begin
      tclk_q <= timer_clock;
      ers_q <= ext_reset_signal;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and optional resync of its output
  // ----------------------------------------------------------------
  wire match = (count_value == period_value);
  wire ext_reset_evt;
  wire scaler_clear = count_wr | ctrl_wr | ext_reset_evt;
  wire pre_tick;
  reg pre_tick_q;

  pth_prescaler u_pre (
    .clock(clock),
    .rst_n(rst_n),
    .clear(scaler_clear),
    .ratio_sel(prescale_q),
    .tick_in(tclk_rise),
    .tick_out(pre_tick)
  );

  always @(posedge clock) begin
    if (!rst_n)
      pre_tick_q <= 1'b0;
    else
      pre_tick_q <= pre_tick;
  end

  // an extra register stage aligns the tick to the instruction clock
  wire tick = prescaler_sync_bit ? pre_tick_q : pre_tick;

  // ----------------------------------------------------------------
  // run bit alignment
  // ----------------------------------------------------------------
  reg run_eff_q;
  always @(posedge clock) begin
    if (!rst_n)
      run_eff_q <= 1'b0;
    else if (!run_bit_sync || tclk_rise)
      run_eff_q <= run_bit;
  end
  // with timer clock alignment run takes effect at the next input edge, whose tick already follows the new run value
  wire run_ok = run_eff_q;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire is_free = (major == `PTH_MAJ_FREE);
  wire is_one = (major == `PTH_MAJ_ONESHOT);
  wire is_mono = (major == `PTH_MAJ_MONO);
  wire edge_rst_req = (option == `PTH_OPT_ANY_EDGE) ? (ers_rise | ers_fall) :
    (option == `PTH_OPT_RISE) ? ers_rise :
    (option == `PTH_OPT_FALL) ? ers_fall : 1'b0;
  reg gate_ok;
  reg lvl_reset;
  reg start_edge;

  always @* begin
    gate_ok = 1'b1;
    lvl_reset = 1'b0;
    start_edge = 1'b0;
    if (is_free) begin
      case (option)
        `PTH_OPT_GATE_HI: gate_ok = ext_reset_signal;
        `PTH_OPT_GATE_LO: gate_ok = ~ext_reset_signal;
        `PTH_OPT_LOW_RST: lvl_reset = ~ext_reset_signal;
        `PTH_OPT_HIGH_RST: lvl_reset = ext_reset_signal;
        default: gate_ok = 1'b1;
      endcase
    end else if (is_one || is_mono) begin
      case (option)
        3'h1, 3'h4, 3'h6: start_edge = ers_rise;
        3'h2, 3'h5, 3'h7: start_edge = ers_fall;
        3'h3: start_edge = ers_rise | ers_fall;
        default: start_edge = 1'b0;
      endcase
      if (is_one && option == `PTH_OPT_LOW_RST)
        lvl_reset = ~ext_reset_signal;
      if (is_one && option == `PTH_OPT_HIGH_RST)
        lvl_reset = ext_reset_signal;
    end
  end

  wire edge_reset = is_free ? edge_rst_req :
    (is_one && (option == `PTH_OPT_RISE || option == `PTH_OPT_FALL)) ?
    edge_rst_req : 1'b0;
  assign ext_reset_evt = edge_reset | lvl_reset;
  wire sw_start = (option == `PTH_OPT_SWGATE);

  // ----------------------------------------------------------------
  // armed state for one-shot and monostable
  // ----------------------------------------------------------------
  reg armed_q;
  reg run_prev_q;
  always @(posedge clock) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_ok;
      if (!run_ok)
        armed_q <= 1'b0;
      else if (tick && match && !is_free)
        armed_q <= 1'b0;
      else if ((sw_start && is_one && !run_prev_q) || start_edge)
        armed_q <= 1'b1;
    end
  end

  wire counting = run_ok && gate_ok && !lvl_reset &&
    (is_free || armed_q);

  // ----------------------------------------------------------------
  // count, period and run bit
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      count_value <= `PTH_CNT_RESET;
      period_value <= `PTH_PER_RESET;
    end else begin
      if (period_wr)
        period_value <= period_wdata;
      if (count_wr)
        count_value <= count_wdata;
      else if (ext_reset_evt)
        count_value <= `PTH_CNT_RESET;
      else if (counting && tick) begin
        if (match)
          count_value <= `PTH_CNT_RESET;
        else
          count_value <= count_value + 8'h01;
      end
      // ctrl_wr alone never touches the count
    end
  end

  always @(posedge clock) begin
    if (!rst_n)
      run_bit <= 1'b0;
    else if (ctrl_wr)
      run_bit <= run_wdata;
    else if (is_one && counting && tick && match)
      run_bit <= 1'b0;
  end

  // ----------------------------------------------------------------
  // postscaler, output pulse and interrupt
  // ----------------------------------------------------------------
  wire post_hit;
  wire [3:0] post_sel = is_one ? 4'h0 : postscale_select;

  pth_postscaler u_post (
    .clock(clock),
    .rst_n(rst_n),
    .clear(scaler_clear),
    .postscale_select(post_sel),
    .match(counting && tick && match),
    .hit(post_hit)
  );

  always @(posedge clock) begin
    if (!rst_n) begin
      postscaled_pulse <= 1'b0;
      irq_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      postscaled_pulse <= post_hit;
      if (post_hit)
        irq_flag <= 1'b1;
      else if (irq_flag_clear)
        irq_flag <= 1'b0;
      irq <= (irq_flag | post_hit) & timer_irq_enable;
    end
  end
endmodule // pth_timer

// File: tb/pth_timer_asserts.sv
// port-level assertion checker for the period timer
`timescale 1ns/100ps
module pth_timer_asserts (
  input logic clock,
  input logic rst_n,
  input logic count_wr,
  input logic [7:0] count_wdata,
  input logic period_wr,
  input logic [7:0] period_wdata,
  input logic ctrl_wr,
  input logic timer_irq_enable,
  input logic irq_flag_clear,
  input logic [7:0] count_value,
  input logic [7:0] period_value,
  input logic run_bit,
  input logic [4:0] mode_q,
  input logic postscaled_pulse,
  input logic irq_flag,
  input logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_stopped;
    !run_bit ##1 (!run_bit && !count_wr && mode_q == 5'h00);
  endsequence
  sequence s_oneshot_end;
    mode_q[4:3] == 2'h1 && $fell(run_bit) && !$past(ctrl_wr) &&
      !$past(ctrl_wr, 2);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_RST_VALUES: assert property ($rose(rst_n) |->
    count_value == 8'h00 && period_value == 8'hFF && !run_bit)
    else $error("reset values wrong");
  AST_COUNT_WRITE: assert property (count_wr |=>
    count_value == $past(count_wdata)) else $error("count write lost");
  AST_PERIOD_WRITE: assert property (period_wr |=>
    period_value == $past(period_wdata)) else $error("period write lost");
  AST_PERIOD_HOLD: assert property (!period_wr |=>
    $stable(period_value)) else $error("period changed unwritten");
  AST_COUNT_STEP: assert property ((count_value != $past(count_value)) &&
    !$past(count_wr) |-> count_value == 8'h00 ||
    count_value - $past(count_value) == 8'h01) else $error("bad count step");
  AST_PULSE_WIDTH: assert property (postscaled_pulse |=>
    !postscaled_pulse) else $error("pulse too wide");
  AST_FLAG_SET: assert property (postscaled_pulse |->
    ##[0:1] irq_flag) else $error("flag not set");
  AST_FLAG_STICKY: assert property (irq_flag && !irq_flag_clear |=>
    irq_flag) else $error("flag dropped");
  // a new hit raises the flag, irq and the pulse at the same edge
  AST_IRQ_GATE: assert property (irq ==
    (($past(irq_flag) || postscaled_pulse) && $past(timer_irq_enable)))
    else $error("irq wrong");
  AST_STOPPED_HOLD: assert property (s_stopped |=>
    $stable(count_value)) else $error("stopped count moved");
  AST_ONESHOT_STOP: assert property (s_oneshot_end |->
    count_value == 8'h00) else $error("one-shot not at zero");
endmodule // pth_timer_asserts

bind pth_timer pth_timer_asserts u_chk (.*);

// File: tb/pth_timer_tb.sv
// self-checking bench for the period timer
`timescale 1ns/100ps
module pth_timer_tb;
  logic clock, rst_n, timer_clock, debug_mode, count_wr, period_wr, ctrl_wr;
  logic limit_wr, run_wdata, prescaler_sync_wdata, run_sync_wdata;
  logic timer_irq_enable, irq_flag_clear, run_bit, postscaled_pulse;
  logic irq_flag, irq;
  logic [7:0] ext_sources, count_wdata, period_wdata, count_value;
  logic [7:0] period_value;
  logic [2:0] reset_source_select, prescale_wdata;
  logic [3:0] postscale_wdata;
  logic [4:0] mode_wdata, mode_q;
  int fails, checked;
  pth_timer uut (.clock, .rst_n, .timer_clock, .ext_sources,
    .reset_source_select, .debug_mode, .count_wr, .count_wdata, .period_wr,
    .period_wdata, .ctrl_wr, .run_wdata, .prescale_wdata, .postscale_wdata,
    .limit_wr, .mode_wdata, .prescaler_sync_wdata, .run_sync_wdata,
    .timer_irq_enable, .irq_flag_clear, .count_value, .period_value,
    .run_bit, .mode_q, .postscaled_pulse, .irq_flag, .irq);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task wrap_up;
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task tk(input int n);
    repeat (n) begin
      timer_clock = 1'b1;
      cyc(1);
      timer_clock = 1'b0;
      cyc(4);
    end
  endtask
  task wc(input logic [7:0] v);
    count_wdata = v;
    count_wr = 1'b1;
    cyc(1);
    count_wr = 1'b0;
    cyc(3);
  endtask
  task wp(input logic [7:0] v);
    period_wdata = v;
    period_wr = 1'b1;
    cyc(1);
    period_wr = 1'b0;
    cyc(3);
  endtask
  task wctl(input logic r, input logic [3:0] pos);
    run_wdata = r;
    postscale_wdata = pos;
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
    cyc(3);
  endtask
  task wlim(input logic [4:0] m, input logic ps);
    mode_wdata = m;
    prescaler_sync_wdata = ps;
    limit_wr = 1'b1;
    cyc(1);
    limit_wr = 1'b0;
    cyc(3);
  endtask
  // only source 2 carries the level, the others show its inverse
  task es(input logic b);
    ext_sources = b ? 8'h04 : 8'hFB;
    cyc(3);
  endtask
  task clr;
    irq_flag_clear = 1'b1;
    cyc(1);
    irq_flag_clear = 1'b0;
    cyc(2);
  endtask
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (8000) @(posedge clock);
    fails++;
    wrap_up;
  end
  initial begin
    {rst_n, timer_clock, debug_mode, count_wr, period_wr, ctrl_wr} = 6'h00;
    {limit_wr, run_wdata, prescaler_sync_wdata, run_sync_wdata} = 4'h0;
    {timer_irq_enable, irq_flag_clear} = 2'h0;
    {count_wdata, period_wdata, mode_wdata} = 21'h000000;
    {prescale_wdata, postscale_wdata} = 7'h00;
    reset_source_select = 3'h2;
    ext_sources = 8'hFB;
    fails = 0;
    checked = 0;
    cyc(20);
    rst_n = 1'b1;
    cyc(1);
    chk(count_value, 8'h00);
    chk(period_value, 8'hFF);
    chk(run_bit, 1'b0);
    wp(8'h05);
    wlim(5'h00, 1'b0);
    timer_irq_enable = 1'b1;
    wctl(1'b1, 4'h0);
    tk(3);
    chk(count_value, 8'h03);
    wctl(1'b1, 4'h0);
    chk(count_value, 8'h03);
    tk(2);
    chk(count_value, 8'h05);
    tk(1);
    chk(count_value, 8'h00);
    chk(irq_flag, 1'b1);
    chk(irq, 1'b1);
    clr;
    chk(irq_flag, 1'b0);
    wc(8'h02);
    wctl(1'b0, 4'h0);
    tk(2);
    chk(count_value, 8'h02);
    wlim(5'h01, 1'b0);
    wctl(1'b1, 4'h0);
    tk(2);
    chk(count_value, 8'h02);
    es(1'b1);
    tk(2);
    chk(count_value, 8'h04);
    wlim(5'h02, 1'b0);
    tk(1);
    chk(count_value, 8'h04);
    es(1'b0);
    tk(1);
    chk(count_value, 8'h05);
    wp(8'h20);
    wlim(5'h04, 1'b0);
    tk(1);
    es(1'b1);
    chk(count_value, 8'h00);
    tk(6);
    es(1'b0);
    debug_mode = 1'b1;
    es(1'b1);
    chk(count_value, 8'h06);
    es(1'b0);
    debug_mode = 1'b0;
    wlim(5'h05, 1'b0);
    es(1'b1);
    tk(6);
    chk(count_value, 8'h0C);
    es(1'b0);
    chk(count_value, 8'h00);
    wlim(5'h03, 1'b0);
    tk(6);
    es(1'b1);
    chk(count_value, 8'h00);
    wlim(5'h07, 1'b0);
    tk(3);
    chk(count_value, 8'h00);
    es(1'b0);
    tk(3);
    chk(count_value, 8'h03);
    wlim(5'h06, 1'b0);
    tk(3);
    chk(count_value, 8'h00);
    es(1'b1);
    tk(1);
    chk(count_value, 8'h01);
    wlim(5'h00, 1'b0);
    es(1'b0);
    tk(1);
    chk(count_value, 8'h02);
    wp(8'h01);
    wc(8'h00);
    clr;
    wctl(1'b1, 4'h1);
    tk(2);
    chk(irq_flag, 1'b0);
    tk(2);
    chk(irq_flag, 1'b1);
    wctl(1'b0, 4'h0);
    wp(8'h03);
    wc(8'h00);
    wlim(5'h08, 1'b0);
    clr;
    wctl(1'b1, 4'h3);
    tk(3);
    chk(count_value, 8'h03);
    tk(1);
    chk(count_value, 8'h00);
    chk(run_bit, 1'b0);
    chk(irq_flag, 1'b1);
    tk(2);
    chk(count_value, 8'h00);
    run_sync_wdata = 1'b1;
    wlim(5'h11, 1'b1);
    chk(mode_q, 8'h11);
    wc(8'h00);
    wctl(1'b1, 4'h0);
    tk(2);
    chk(count_value, 8'h00);
    es(1'b1);
    tk(2);
    chk(count_value, 8'h02);
    tk(6);
    chk(count_value, 8'h00);
    chk(run_bit, 1'b1);
    es(1'b0);
    es(1'b1);
    tk(2);
    chk(count_value, 8'h02);
    wrap_up;
  end
endmodule // pth_timer_tb
